// *** rtl/dbrt_pkg.sv ***
package dbrt_pkg;

    // Clock rate
    localparam longint CLK_HZ = 25000000;

    // Hold times per delay-select state, in seconds
    localparam longint HOLD_OPEN_S  = 2;
    localparam longint HOLD_LOW_S   = 4;
    localparam longint HOLD_HIGH_S  = 6;
    localparam longint HOLD_OPEN_CYC = HOLD_OPEN_S * CLK_HZ;
    localparam longint HOLD_LOW_CYC  = HOLD_LOW_S * CLK_HZ;
    localparam longint HOLD_HIGH_CYC = HOLD_HIGH_S * CLK_HZ;

    // Reset pulse length options, in milliseconds (typical figures)
    localparam longint PULSE_X_MS  = 220;
    localparam longint PULSE_Y_MS  = 350;
    localparam longint PULSE_X_CYC = PULSE_X_MS * (CLK_HZ / 1000);
    localparam longint PULSE_Y_CYC = PULSE_Y_MS * (CLK_HZ / 1000);

    // Counter width, enough for the longest hold time
    localparam int CNT_W = 28;

    // Delay-select decode: the pin is seen as drive value plus drive enable
    typedef enum logic [1:0] {
        DBRT_SEL_OPEN = 2'h0,
        DBRT_SEL_LOW  = 2'h1,
        DBRT_SEL_HIGH = 2'h3
    } dbrt_sel_t;

    // Sequencer states, Gray coded along idle -> hold -> pulse -> release
    typedef enum logic [1:0] {
        DBRT_IDLE    = 2'h0,
        DBRT_HOLD    = 2'h1,
        DBRT_PULSE   = 2'h3,
        DBRT_RELEASE = 2'h2
    } dbrt_state_t;

endpackage

// *** rtl/dbrt_reset_timer.sv ***
// Functional notes
// - Output reset_out_high rises once both requests stay low for the whole hold time.
// - reset_out_high stays high for the pulse length after the hold time, then falls.
// - The open-drain active-low reset is pulled low when both requests held low for the hold time.
// - The open-drain reset stays asserted for the pulse length, in step with reset_out_high.
// - One qualified hold yields exactly one pulse, never a train.
// - Hold time is 2 s with selector open, 4 s tied low, 6 s tied to supply.
// - Each manual request is asserted while low and inactive while high.
`timescale 1ns/1ps
module dbrt_reset_timer #(
    parameter bit     PULSE_OPTION_Y = 1'b0,
    parameter longint HOLD_OPEN_CYC  = dbrt_pkg::HOLD_OPEN_CYC,
    parameter longint HOLD_LOW_CYC   = dbrt_pkg::HOLD_LOW_CYC,
    parameter longint HOLD_HIGH_CYC  = dbrt_pkg::HOLD_HIGH_CYC,
    parameter longint PULSE_X_CYC    = dbrt_pkg::PULSE_X_CYC,
    parameter longint PULSE_Y_CYC    = dbrt_pkg::PULSE_Y_CYC
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic manual_req_a_n,
    input  wire logic manual_req_b_n,
    input  wire logic hold_delay_select_in,
    input  wire logic hold_delay_select_driven,
    output logic      reset_out_high,
    output logic      reset_out_n_out,
    output logic      reset_out_n_oe
);

    // How a press travels through the block, edge by edge:
    //   edge 0      both button pins go low
    //   edge 1..2   the low level walks through the two synchroniser flops
    //   edge 3      the sequencer leaves idle and starts the hold count at zero
    //   hold edges  the count climbs while both stay low; the selector is read live,
    //               so moving it mid-hold changes the limit on the next compare
    //   last hold   the compare hits, both outputs rise on that same edge
    //   pulse edges the outputs stand for exactly the pulse length, whatever the
    //               buttons do meanwhile
    //   release     nothing new starts until both buttons are seen up again
    //
    // Hazards kept in mind:
    //   - A button that bounces up during the hold drops the count to zero, so a
    //     shaky press can never add up partial holds into one long one.
    //   - Buttons still held after the pulse would otherwise start a second hold
    //     at once and give a train of pulses; the release state blocks that.
    //   - Both outputs are made from one registered decision, so the push-pull
    //     output and the open-drain enable cannot slip a cycle against each other.
    //   - Reset levels of the synchronisers match the idle pins, so leaving reset
    //     with the buttons up never looks like a press.
    //
    // Limitations:
    //   - The pulse length uses the typical figures; a target that needs the
    //     minimum must not rely on anything longer.
    //   - The counter width covers the longest hold for clocks up to about 44.7 MHz; a
    //     faster clock needs a wider counter in the package.
    //   - The open selector state is seen through the driven flag only; a weakly
    //     held pin that the pad reads as driven selects the tied states.

    localparam logic [dbrt_pkg::CNT_W-1:0] PULSE_CYC = dbrt_pkg::CNT_W'(
        PULSE_OPTION_Y ? PULSE_Y_CYC : PULSE_X_CYC);

    // Hold limit for a selector state; minus one as the counter starts at zero
    function automatic logic [dbrt_pkg::CNT_W-1:0] hold_limit(input logic [1:0] sel);
        case (sel)
            dbrt_pkg::DBRT_SEL_LOW:  hold_limit = dbrt_pkg::CNT_W'(HOLD_LOW_CYC - 1);
            dbrt_pkg::DBRT_SEL_HIGH: hold_limit = dbrt_pkg::CNT_W'(HOLD_HIGH_CYC - 1);
            default:                 hold_limit = dbrt_pkg::CNT_W'(HOLD_OPEN_CYC - 1);
        endcase
    endfunction

    // Synchroniser bank: one slot per pin that arrives from outside the clock domain
    localparam int                SYNC_N      = 4;
    localparam int                PIN_A       = 0;
    localparam int                PIN_B       = 1;
    localparam int                PIN_SEL_IN  = 2;
    localparam int                PIN_SEL_DRV = 3;
    // Reset levels: buttons up, selector open, so no false press follows reset
    localparam logic [SYNC_N-1:0] PIN_IDLE    = 4'h3;

    // Tri-state selector seen as level plus driven flag; an open pin reads as open
    function automatic logic [1:0] sel_code(input logic level, input logic driven);
        sel_code = {level & driven, driven};
    endfunction

    logic [SYNC_N-1:0]          pinRaw;
    logic [SYNC_N-1:0]          pinMeta;
    logic [SYNC_N-1:0]          pinSync;
    logic                       reqAIdle;
    logic                       reqBIdle;
    logic                       bothLow;
    logic [1:0]                 selCode;
    logic [dbrt_pkg::CNT_W-1:0] holdLimit;
    logic                       next_pulse;
    logic [dbrt_pkg::CNT_W-1:0] count;
    dbrt_pkg::dbrt_state_t      state;

    // Pack the raw pins in slot order
    assign pinRaw[PIN_A]       = manual_req_a_n;
    assign pinRaw[PIN_B]       = manual_req_b_n;
    assign pinRaw[PIN_SEL_IN]  = hold_delay_select_in;
    assign pinRaw[PIN_SEL_DRV] = hold_delay_select_driven;

    // Two flops per pin; only the second flop of each slot is read by logic
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta <= PIN_IDLE;
            pinSync <= PIN_IDLE;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    // A request counts only while its pin is low
    assign reqAIdle  = pinSync[PIN_A];
    assign reqBIdle  = pinSync[PIN_B];
    assign bothLow   = !reqAIdle && !reqBIdle;
    assign selCode   = sel_code(pinSync[PIN_SEL_IN], pinSync[PIN_SEL_DRV]);
    assign holdLimit = hold_limit(selCode);

    // Sequencer: idle, timed hold, fixed pulse, wait for both buttons up
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= dbrt_pkg::DBRT_IDLE;
            count <= '0;
        end else begin
            case (state)
                dbrt_pkg::DBRT_IDLE: begin
                    count <= '0;
                    if (bothLow) begin
                        state <= dbrt_pkg::DBRT_HOLD;
                    end
                end
                dbrt_pkg::DBRT_HOLD: begin
                    if (!bothLow) begin
                        state <= dbrt_pkg::DBRT_IDLE;
                        count <= '0;
                    end else if (count >= hold_limit(selCode)) begin
                        state <= dbrt_pkg::DBRT_PULSE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                dbrt_pkg::DBRT_PULSE: begin
                    // Pulse length is fixed; button state does not cut it short
                    if (count >= PULSE_CYC - 1'b1) begin
                        state <= dbrt_pkg::DBRT_RELEASE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                dbrt_pkg::DBRT_RELEASE: begin
                    // Still-held buttons must not start another pulse
                    count <= '0;
                    if (reqAIdle && reqBIdle) begin
                        state <= dbrt_pkg::DBRT_IDLE;
                    end
                end
                default: begin
                    state <= dbrt_pkg::DBRT_IDLE;
                    count <= '0;
                end
            endcase
        end
    end

    // One decision feeds both outputs, so they cannot drift apart
    function automatic logic pulse_due(
        input dbrt_pkg::dbrt_state_t      st,
        input logic                       low,
        input logic [dbrt_pkg::CNT_W-1:0] cnt,
        input logic [dbrt_pkg::CNT_W-1:0] lim
    );
        pulse_due = (st == dbrt_pkg::DBRT_HOLD && low && cnt >= lim) ||
                    (st == dbrt_pkg::DBRT_PULSE && cnt < PULSE_CYC - 1'b1);
    endfunction

    // Rises on the edge that ends the hold, falls after the pulse length
    assign next_pulse = pulse_due(state, bothLow, count, holdLimit);

    // Push-pull output, registered so it never glitches
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_out_high <= 1'b0;
        end else begin
            reset_out_high <= next_pulse;
        end
    end

    // Open-drain data never drives high; the line's pull-up gives the idle level
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_out_n_out <= 1'b0;
        end else begin
            reset_out_n_out <= 1'b0;
        end
    end

    // Open-drain enable: high while the line is pulled low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_out_n_oe <= 1'b0;
        end else begin
            reset_out_n_oe <= next_pulse;
        end
    end

endmodule

// *** tb/dbrt_chk.sv ***
`timescale 1ns/1ps
module dbrt_chk #(parameter longint PULSE = 10) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic manual_req_a_n,
    input wire logic manual_req_b_n,
    input wire logic reset_out_high,
    input wire logic reset_out_n_out,
    input wire logic reset_out_n_oe
);
    longint hiCnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Cycles the pulse has stood so far; a counter, as the width is beyond a repetition
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            hiCnt <= 0;
        else
            hiCnt <= reset_out_high ? hiCnt + 1 : 0;
    end
    in_step_a: assert property (reset_out_high == reset_out_n_oe)
        else $error("outputs split");
    od_data_a: assert property (!reset_out_n_out)
        else $error("open drain data high");
    reset_idle_a: assert property ($rose(resetn) |-> !reset_out_n_oe)
        else $error("pulse right after reset");
    pulse_len_a: assert property ($fell(reset_out_high) |-> hiCnt == PULSE)
        else $error("pulse width wrong");
    full_pulse_a: assert property (reset_out_high && hiCnt < PULSE - 1 |=> reset_out_high)
        else $error("pulse cut short");
    both_low_a: assert property ($rose(reset_out_high) |->
        !$past(manual_req_a_n, 3) && !$past(manual_req_b_n, 3)) else $error("rise without hold");
    long_hold_a: assert property ($rose(reset_out_high) |-> !$past(manual_req_b_n, 18))
        else $error("hold too short");
    no_train_a: assert property ($fell(reset_out_high) && !manual_req_a_n |=> !reset_out_high [*8])
        else $error("second pulse");
    cover property ($rose(reset_out_high));
    cover property ($fell(reset_out_high) && !manual_req_b_n);
    cover property (!manual_req_a_n ##1 manual_req_b_n);
endmodule
bind dbrt_reset_timer dbrt_chk #(.PULSE(PULSE_OPTION_Y ? PULSE_Y_CYC : PULSE_X_CYC)) chk_inst (
    .sys_clk, .resetn, .manual_req_a_n, .manual_req_b_n, .reset_out_high, .reset_out_n_out,
    .reset_out_n_oe);

// *** tb/dbrt_target.sv ***
`timescale 1ns/1ps
module dbrt_target (
    input  wire logic odOut,
    input  wire logic odOe,
    output wire logic rstLine,
    output int        falls
);
    // Pull-up holds the line high whenever the device lets go
    assign rstLine = odOe ? odOut : 1'h1;
    initial falls = 0;
    always @(negedge rstLine) falls++;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    localparam longint HO = 20, HL = 40, HH = 60, PX = 10, PY = 15;
    logic        sysClk = 1'h0;
    logic        resetn = 1'h0;
    logic        reqA = 1'h1;    // Buttons idle high, never floating
    logic        reqB = 1'h1;
    logic [1:0]  sel = 2'h0;
    logic        rstHigh, rstOut, rstOe, rstLine, rstHighY;
    logic [31:0] seed = 29;
    logic [1:0]  sels [3] = '{2'h0, 2'h1, 2'h3};
    int          falls, num_errors = 0, num_checks = 0, cyc = 0;
    dbrt_reset_timer #(.HOLD_OPEN_CYC(HO), .HOLD_LOW_CYC(HL), .HOLD_HIGH_CYC(HH),
        .PULSE_X_CYC(PX)) dbrt_reset_timer_inst (.sys_clk(sysClk), .resetn(resetn),
        .manual_req_a_n(reqA), .manual_req_b_n(reqB), .hold_delay_select_in(sel[1]),
        .hold_delay_select_driven(sel[0]), .reset_out_high(rstHigh),
        .reset_out_n_out(rstOut), .reset_out_n_oe(rstOe));
    dbrt_target dbrt_target_inst (.odOut(rstOut), .odOe(rstOe), .rstLine(rstLine), .falls(falls));
    // Second build with the long pulse option, same buttons and selector
    dbrt_reset_timer #(.PULSE_OPTION_Y(1'b1), .HOLD_OPEN_CYC(HO), .HOLD_LOW_CYC(HL),
        .HOLD_HIGH_CYC(HH), .PULSE_Y_CYC(PY)) dbrt_reset_timer_inst_y (.sys_clk(sysClk),
        .resetn(resetn), .manual_req_a_n(reqA), .manual_req_b_n(reqB),
        .hold_delay_select_in(sel[1]), .hold_delay_select_driven(sel[0]),
        .reset_out_high(rstHighY), .reset_out_n_out(), .reset_out_n_oe());
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Open, tied low, tied to supply
    function automatic longint holdOf(logic [1:0] s);
        return s == 2'h0 ? HO : s == 2'h1 ? HL : HH;
    endfunction
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            num_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Press both; B lets go after relAt edges if set; hold 0 means no pulse expected
    task automatic press(logic [1:0] s, int relAt, longint hold);
        int n;
        int f;
        int w;
        sel = s;
        reqA = 1'h0;
        reqB = 1'h0;
        f = falls;
        for (n = 0; !rstHigh && n < 150; n++) begin
            @(posedge sysClk);
            #1 reqB = (n + 1 == relAt) ? 1'h1 : reqB;
        end
        cmp("delay", 1'h1, hold == 0 ? n == 150 : n > hold && n < hold + 6);
        w = 0;
        for (n = 0; (rstHigh || rstHighY) && n < 50; n++) begin
            if (rstHigh) begin
                w++;
                cmp("line", 1'h0, rstLine);
            end
            @(posedge sysClk);
            #1;
        end
        repeat (60) @(posedge sysClk);
        cmp("pulses", hold ? f + 1 : f, falls);
        cmp("width", hold ? PX : 0, w);
        cmp("width_y", hold ? PY : 0, n);
        #1 reqA = 1'h1;
        reqB = 1'h1;
        repeat (8) @(posedge sysClk);
        #1;
    endtask
    initial forever #20 sysClk = ~sysClk;
    // Whole run needs about 2300 cycles; far beyond that means a hang
    always @(posedge sysClk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test;
        end
    end
    initial begin
        repeat (16) @(posedge sysClk);
        #1 resetn = 1'h1;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            press(sels[i % 3], 0, holdOf(sels[i % 3]));
            press(sels[i % 3], 1 + seed % (holdOf(sels[i % 3]) - 4), 0);
        end
        press(2'h0, 1, 0);
        end_of_test;
    end
endmodule
